// [logic/ira_i2c_target.v]
// I2C target engine for register access: address match, register pointer,
// single and burst writes and reads, acknowledge generation.
// Assumes scl and sda are oversampled at 10 MHz and synchronous to clock;
// the register core answers rd_data combinationally from reg_ptr.
// The data line is only ever pulled low; its pull-up supplies every one.
`include "ira_defs.vh"

module ira_i2c_target (
  input wire clock,                 // System clock, 10 MHz.
  input wire rstn,                  // Asynchronous reset, active low.
  input wire scl,                   // Bus clock level.
  input wire sda_in,                // Bus data level.
  output reg sda_out,               // Data drive value, always low.
  output reg sda_oe_n,              // Data drive enable, active low.
  input wire address_select_one,    // Upper address strap pin.
  input wire address_select_zero,   // Lower address strap pin.
  input wire [7:0] rd_data,         // Register value at reg_ptr.
  output reg [7:0] reg_ptr,         // Current register pointer.
  output reg [7:0] wr_data,         // Received write byte.
  output reg wr_strobe,             // One-cycle pulse, write wr_data.
  output reg rd_strobe,             // One-cycle pulse, byte taken.
  output reg ready                  // High once start-up time is over.
);

  // =====================================================================
  // States
  localparam ST_IDLE = 4'h0;
  localparam ST_ADDR = 4'h1;
  localparam ST_ADDR_ACK = 4'h2;
  localparam ST_REGA = 4'h3;
  localparam ST_REGA_ACK = 4'h4;
  localparam ST_WDATA = 4'h5;
  localparam ST_WDATA_ACK = 4'h6;
  localparam ST_RDATA = 4'h7;
  localparam ST_RACK = 4'h8;
  localparam ST_IGNORE = 4'h9;

  // The start-up count fits twelve bits; the cut below is deliberate.
  localparam integer READY_INT = `IRA_READY_CYCLES;
  localparam [11:0] READY_COUNT = READY_INT[11:0];

  // Engine state, byte shifter and bus history.
  reg [3:0] state;
  reg [3:0] bit_cnt;
  reg [7:0] shift;
  reg rd_dir;
  reg scl_q;
  reg sda_q;
  reg first_fall;
  reg [11:0] ready_cnt;
  reg [7:0] own_addr;
  // Decoded bus events and strap results.
  wire [1:0] code_one;
  wire [1:0] code_zero;
  wire scl_rise;
  wire scl_fall;
  wire start_cond;
  wire stop_cond;
  wire bus_idle;
  wire [7:0] byte_in;

  // =====================================================================
  // Bus events
  // A data change while the clock stays high is a control condition.
  assign scl_rise = scl & ~scl_q;
  assign scl_fall = ~scl & scl_q;
  assign start_cond = scl & scl_q & sda_q & ~sda_in; // R18
  assign stop_cond = scl & scl_q & ~sda_q & sda_in; // R18
  assign bus_idle = (state == ST_IDLE) & scl & sda_in;
  assign byte_in = {shift[6:0], sda_in};

  // Previous levels, used only for edge and condition detection.
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl;
      sda_q <= sda_in;
    end
  end

  // =====================================================================
  // Address straps
  // Both straps are classified alike, once per START, from the same events.
  ira_strap_decode u_strap_one (
    .clock(clock),
    .rstn(rstn),
    .pin(address_select_one),
    .bus_idle(bus_idle),
    .start_seen(start_cond),
    .first_low(first_fall & scl_fall),
    .code(code_one)
  );

  ira_strap_decode u_strap_zero (
    .clock(clock),
    .rstn(rstn),
    .pin(address_select_zero),
    .bus_idle(bus_idle),
    .start_seen(start_cond),
    .first_low(first_fall & scl_fall),
    .code(code_zero)
  );

  // Strap codes select one of sixteen write addresses.
  always @* begin
    case ({code_one, code_zero})
      4'h0: own_addr = `IRA_TADDR_0; // R17
      4'h1: own_addr = `IRA_TADDR_1;
      4'h2: own_addr = `IRA_TADDR_2;
      4'h3: own_addr = `IRA_TADDR_3;
      4'h4: own_addr = `IRA_TADDR_4;
      4'h5: own_addr = `IRA_TADDR_5;
      4'h6: own_addr = `IRA_TADDR_6;
      4'h7: own_addr = `IRA_TADDR_7;
      4'h8: own_addr = `IRA_TADDR_8;
      4'h9: own_addr = `IRA_TADDR_9;
      4'hA: own_addr = `IRA_TADDR_10;
      4'hB: own_addr = `IRA_TADDR_11;
      4'hC: own_addr = `IRA_TADDR_12;
      4'hD: own_addr = `IRA_TADDR_13;
      4'hE: own_addr = `IRA_TADDR_14;
      default: own_addr = `IRA_TADDR_15;
    endcase
  end

  // =====================================================================
  // Start-up timer
  // The bus is ignored until the count expires, so early polls see no
  // acknowledge and the host simply retries.
  // A plain counter on the system clock avoids a second timing source.
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ready_cnt <= 12'h000;
      ready <= 1'b0;
    end else if (!ready) begin
      if (ready_cnt == READY_COUNT - 12'h001) begin
        ready <= 1'b1; // R14
      end
      ready_cnt <= ready_cnt + 12'h001;
    end
  end

  // =====================================================================
  // Protocol engine
  // Bits are sampled on clock rise and the data line only changes after a
  // clock fall, so the drive is settled well before the next rise.
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state <= ST_IDLE;
      bit_cnt <= 4'h0;
      shift <= 8'h00;
      rd_dir <= 1'b0;
      first_fall <= 1'b0;
      sda_out <= 1'b0;
      sda_oe_n <= 1'b1;
      reg_ptr <= 8'h00;
      wr_data <= 8'h00;
      wr_strobe <= 1'b0;
      rd_strobe <= 1'b0;
    end else begin
      // Strobes last one cycle unless a branch below raises them.
      wr_strobe <= 1'b0;
      rd_strobe <= 1'b0;
      if (scl_fall) begin
        first_fall <= 1'b0;
      end
      // Until start-up ends the engine stays idle and off the bus.
      if (!ready) begin
        state <= ST_IDLE;
        sda_oe_n <= 1'b1;
      end else if (start_cond) begin
        // START or repeated START always restarts address reception.
        state <= ST_ADDR; // R1
        bit_cnt <= 4'h0;
        first_fall <= 1'b1;
        sda_oe_n <= 1'b1;
      end else if (stop_cond) begin
        // STOP releases the bus; a byte cut short is dropped.
        state <= ST_IDLE;
        sda_oe_n <= 1'b1;
      end else begin
        case (state)
          // Byte reception: address, register address and write data share one
          // shifter; the fall after the eighth bit decides the acknowledge.
          ST_ADDR, ST_REGA, ST_WDATA: begin
            // Bits are taken on the rise; the eighth completes the byte.
            if (scl_rise) begin
              shift <= byte_in;
              bit_cnt <= bit_cnt + 4'h1;
              if (bit_cnt == 4'h7 && state == ST_WDATA) begin
                wr_data <= byte_in;
                wr_strobe <= 1'b1; // R5 R6
              end
            end
            // Drive the acknowledge in the low phase, well before the ninth rise.
            if (scl_fall && bit_cnt == 4'h8) begin
              bit_cnt <= 4'h0;
              if (state == ST_ADDR) begin
                if (shift[7:1] == own_addr[7:1]) begin
                  rd_dir <= shift[0];
                  sda_oe_n <= 1'b0; // R2 R12
                  state <= ST_ADDR_ACK;
                end else begin
                  state <= ST_IGNORE; // R19
                end
              end else if (state == ST_REGA) begin
                reg_ptr <= shift; // R3
                if (shift <= `IRA_REG_LAST) begin
                  sda_oe_n <= 1'b0; // R4
                end
                state <= ST_REGA_ACK; // R13
              end else begin
                if (reg_ptr != `IRA_REG_FIFO) begin
                  reg_ptr <= reg_ptr + 8'h01; // R7
                end
                sda_oe_n <= 1'b0; // R6 R12
                state <= ST_WDATA_ACK;
              end
            end
          end
          // Address acknowledge ends: a write waits for the register address,
          // a read loads the addressed register and starts sending at once.
          ST_ADDR_ACK: begin
            if (scl_fall) begin
              if (rd_dir) begin
                // First data bit goes out as the acknowledge ends.
                shift <= {rd_data[6:0], 1'b0}; // R8 R9
                sda_oe_n <= rd_data[7];
                rd_strobe <= 1'b1;
                bit_cnt <= 4'h1;
                state <= ST_RDATA;
              end else begin
                sda_oe_n <= 1'b1;
                state <= ST_REGA;
              end
            end
          end
          // The drive level during the ninth clock tells a taken register
          // address from a refused one when that clock falls.
          ST_REGA_ACK: begin
            if (scl_fall) begin
              sda_oe_n <= 1'b1;
              // Invalid register: drop further bytes until a new START.
              state <= sda_oe_n ? ST_IGNORE : ST_WDATA; // R4
            end
          end
          // Write acknowledge ends; another data byte may follow.
          ST_WDATA_ACK: begin
            if (scl_fall) begin
              sda_oe_n <= 1'b1;
              state <= ST_WDATA; // R6
            end
          end
          // Read byte: one new bit per clock fall, most significant first. The
          // pointer steps before the answer so the next byte is ready in time.
          ST_RDATA: begin
            if (scl_fall) begin
              if (bit_cnt == 4'h8) begin
                sda_oe_n <= 1'b1;
                if (reg_ptr != `IRA_REG_FIFO) begin
                  reg_ptr <= reg_ptr + 8'h01; // R7
                end
                state <= ST_RACK;
              end else begin
                sda_oe_n <= shift[7]; // R9 R19
                shift <= {shift[6:0], 1'b0};
                bit_cnt <= bit_cnt + 4'h1;
              end
            end
          end
          // Controller answer: an acknowledge keeps the burst going, a
          // not-acknowledge ends it until the next START or STOP.
          ST_RACK: begin
            if (scl_rise) begin
              // Controller acknowledge asks for another byte.
              state <= sda_in ? ST_IGNORE : ST_RACK; // R10 R11 R13
            end
            if (scl_fall) begin
              shift <= {rd_data[6:0], 1'b0}; // R11
              sda_oe_n <= rd_data[7];
              rd_strobe <= 1'b1;
              bit_cnt <= 4'h1;
              state <= ST_RDATA;
            end
          end
          // Foreign address or refused access: stay off the bus.
          ST_IGNORE: begin
            sda_oe_n <= 1'b1; // R19
          end
          // Waiting for a START.
          ST_IDLE: begin
            sda_oe_n <= 1'b1;
          end
          // Unused codes fall back to idle with the bus released.
          default: begin
            state <= ST_IDLE;
            sda_oe_n <= 1'b1;
          end
        endcase
      end
    end
  end

endmodule

// [logic/ira_defs.vh]
// Constants for the I2C register access target: strap codes, address table,
// register window and start-up timing.
// Assumes a 10 MHz system clock and bus pins already synchronous to it.
//
// Notes on behaviour
// R1 - Controller opens with START, address, write.
// R2 - Acknowledge address byte matching the strapped address.
// R3 - Controller then sends the register address byte.
// R4 - Acknowledge valid register address, otherwise not-acknowledge.
// R5 - Single write: acknowledge data byte, then STOP.
// R6 - Burst write: acknowledge every data byte.
// R7 - Pointer advances per byte, holds at 0x00.
// R8 - Read needs repeated START, address, read.
// R9 - Read address acknowledged, send addressed register byte.
// R10 - Controller ends single read with NACK, STOP.
// R11 - Burst read continues while controller acknowledges.
// R12 - Acknowledge: data low before and through ninth clock.
// R13 - Not-acknowledge: data left released on ninth clock.
// R14 - Ready for accesses within about 200 us.
// R15 - Host polls a known register until ready.
// R16 - Host uses interrupt output or polls status.
// R17 - Two four-level straps select sixteen addresses.
// R18 - Data change while clock high is START/STOP.
// R19 - Drive low only; ignore traffic after mismatch.
`ifndef IRA_DEFS_VH
`define IRA_DEFS_VH

// =====================================================================
// Strap levels seen on an address select pin.
`define IRA_STRAP_GND 2'h0
`define IRA_STRAP_VL 2'h1
`define IRA_STRAP_SCL 2'h2
`define IRA_STRAP_SDA 2'h3

// =====================================================================
// Eight-bit write addresses, indexed by {select_one, select_zero} codes.
`define IRA_TADDR_0 8'hD8
`define IRA_TADDR_1 8'hC2
`define IRA_TADDR_2 8'hC4
`define IRA_TADDR_3 8'hC6
`define IRA_TADDR_4 8'hC8
`define IRA_TADDR_5 8'hCA
`define IRA_TADDR_6 8'hCC
`define IRA_TADDR_7 8'hCE
`define IRA_TADDR_8 8'hD0
`define IRA_TADDR_9 8'hD2
`define IRA_TADDR_10 8'hD4
`define IRA_TADDR_11 8'hD6
`define IRA_TADDR_12 8'hC0
`define IRA_TADDR_13 8'hDA
`define IRA_TADDR_14 8'hDC
`define IRA_TADDR_15 8'hDE

// =====================================================================
// Register window and the address that does not auto-increment.
`define IRA_REG_LAST 8'h1F
`define IRA_REG_FIFO 8'h00

// =====================================================================
// Start-up time and its cycle count at 100 ns per clock.
`define IRA_CLK_PERIOD_NS 100
`define IRA_READY_TIME_US 200
`define IRA_READY_CYCLES ((`IRA_READY_TIME_US * 1000) / `IRA_CLK_PERIOD_NS)

`endif

// [logic/ira_strap_decode.v]
// One address select strap classifier: tells ground, logic supply, clock
// or data wiring apart by watching the pin against the bus.
// Assumes the pin, scl and sda are synchronous to clock.
`include "ira_defs.vh"

module ira_strap_decode (
  input wire clock,          // System clock.
  input wire rstn,           // Asynchronous reset, active low.
  input wire pin,            // Strap pin level.
  input wire bus_idle,       // Both bus lines high, no transfer.
  input wire start_seen,     // Pulse on a START condition.
  input wire first_low,      // Pulse on first clock fall after START.
  output reg [1:0] code      // Classified strap level.
);

  reg idle_lvl;
  reg start_lvl;

  // =====================================================================
  // Classification
  // Idle shows ground apart; START (data low, clock high) shows data wiring;
  // the first clock low shows clock wiring. Anything else is the supply.
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      idle_lvl <= 1'b1;
      start_lvl <= 1'b1;
      code <= `IRA_STRAP_VL;
    end else begin
      if (bus_idle) begin
        idle_lvl <= pin;
      end
      if (start_seen) begin
        start_lvl <= pin;
      end
      if (first_low) begin
        if (!idle_lvl) begin
          code <= `IRA_STRAP_GND; // R17
        end else if (!start_lvl) begin
          code <= `IRA_STRAP_SDA; // R17
        end else if (!pin) begin
          code <= `IRA_STRAP_SCL; // R17
        end else begin
          code <= `IRA_STRAP_VL; // R17
        end
      end
    end
  end

endmodule

// [verif/ira_host_model.sv]
// Bus controller model: makes the bus clock and pulls the data wire low.
// Assumes the bench resolves the data wire from both pull-downs and a pull-up.
module ira_host_model (
  input wire clock,     // System clock.
  input wire sda,       // Resolved data wire.
  output logic scl,     // Bus clock, idle high.
  output logic sda_low  // Pulls the data wire low when set.
);
  timeunit 1ns;
  timeprecision 1ns;

  // =====================================================
  // Bus idles released, clock high.
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // Every bus change lands a fixed 5 ns after a clock edge.
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #5;
  endtask

  // Data moves only while the clock is low, four cycles per phase.
  task automatic bit_io(input logic b, output logic r);
    sda_low = !b;
    tick(4);
    scl = 1'b1;
    tick(4);
    r = sda;
    scl = 1'b0;
  endtask

  // A start from idle, or a repeated start after a byte.
  task automatic start();
    sda_low = 1'b0;
    tick(4);
    scl = 1'b1;
    tick(4);
    sda_low = 1'b1;
    tick(4);
    scl = 1'b0;
  endtask

  // A stop leaves the bus idle for a few cycles.
  task automatic stop();
    sda_low = 1'b1;
    tick(4);
    scl = 1'b1;
    tick(4);
    sda_low = 1'b0;
    tick(4);
  endtask

  // One byte out and its acknowledge bit; a read sends all ones.
  task automatic xfer(input logic [7:0] d, input logic ak, output logic [7:0] q, output logic a);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(ak, a);
  endtask
endmodule

// [verif/ira_target_properties.sv]
// Timing checks on the bus target, watching only its ports.
// Assumes one clock domain with an asynchronous active-low reset.
module ira_target_props (
  input wire clock,               // System clock.
  input wire rstn,                // Reset, active low.
  input wire scl,                 // Bus clock.
  input wire sda_in,              // Data wire.
  input wire sda_out,             // Drive value.
  input wire sda_oe_n,            // Drive enable, active low.
  input wire address_select_one,  // Upper strap.
  input wire address_select_zero, // Lower strap.
  input wire [7:0] rd_data,       // Register read value.
  input wire [7:0] reg_ptr,       // Register pointer.
  input wire [7:0] wr_data,       // Written byte.
  input wire wr_strobe,           // Write pulse.
  input wire rd_strobe,           // Read pulse.
  input wire ready                // Start-up done.
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);

  // =====================================================
  // Pointer seen at a write strobe, kept until its acknowledge ends.
  logic [7:0] wp;
  logic pend;
  logic oe_q;
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      wp <= 8'h00;
      pend <= 1'b0;
      oe_q <= 1'b1;
    end else begin
      oe_q <= sda_oe_n;
      if (wr_strobe) begin
        wp <= reg_ptr;
        pend <= 1'b1;
      end else if (sda_oe_n && !oe_q) begin
        pend <= 1'b0;
      end
    end
  end

  // =====================================================
  // Bus and register side relations.
  drive_low_a: assert property (sda_out == 1'b0) else $error("Drive value not low.");
  quiet_unready_a: assert property (!ready |-> sda_oe_n) else $error("Drive before ready.");
  ready_stays_a: assert property (ready |=> ready) else $error("Ready dropped.");
  stable_high_a: assert property (scl && $past(scl) |-> $stable(sda_oe_n))
    else $error("Drive moved in clock high.");
  change_low_a: assert property ($changed(sda_oe_n) |-> !scl) else $error("Drive moved at rise.");
  wr_pulse_a: assert property (wr_strobe |=> !wr_strobe) else $error("Write strobe too long.");
  wr_ack_a: assert property (wr_strobe |-> ##[1:40] $fell(sda_oe_n))
    else $error("Write byte not acknowledged.");
  ptr_step_a: assert property (pend && $rose(sda_oe_n) |-> reg_ptr == ((wp == 8'h00) ? 8'h00 : wp + 8'h01))
    else $error("Pointer step wrong.");
  read_bit_a: assert property (rd_strobe |-> sda_oe_n == rd_data[7]) else $error("First bit wrong.");
  rd_space_a: assert property (rd_strobe |=> !rd_strobe [*4]) else $error("Read strobes too close.");

  // A write, a burst read and the end of start-up are reached.
  cover property (wr_strobe);
  cover property (rd_strobe ##[1:100] rd_strobe);
  cover property ($rose(ready));
endmodule

bind ira_i2c_target ira_target_props chk_u (.clock(clock), .rstn(rstn), .scl(scl), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe_n(sda_oe_n), .address_select_one(address_select_one),
  .address_select_zero(address_select_zero), .rd_data(rd_data), .reg_ptr(reg_ptr), .wr_data(wr_data),
  .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .ready(ready));

// [verif/tb.sv]
// Self-checking bench: host model on the bus, register file on the core side.
// Assumes the target header is on the include path.
`include "ira_defs.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic [3:0] strap = 4'h0;
  logic [7:0] taddr = `IRA_TADDR_0;
  logic [7:0] mem [32];
  logic [7:0] shadow [32];
  logic [15:0] wq [$];
  logic [7:0] rq [$];
  logic [7:0] tab [16] = '{`IRA_TADDR_0, `IRA_TADDR_1, `IRA_TADDR_2, `IRA_TADDR_3, `IRA_TADDR_4, `IRA_TADDR_5,
    `IRA_TADDR_6, `IRA_TADDR_7, `IRA_TADDR_8, `IRA_TADDR_9, `IRA_TADDR_10, `IRA_TADDR_11, `IRA_TADDR_12,
    `IRA_TADDR_13, `IRA_TADDR_14, `IRA_TADDR_15};
  int fail_count = 0;
  int comparisons = 0;
  wire scl, sda_low, sda, sel_one, sel_zero, sda_out, sda_oe_n, wr_strobe, rd_strobe, ready;
  wire [7:0] reg_ptr, wr_data, rd_data;

  // =====================================================
  // Pull-up wire, strap wiring and a plain register file.
  always #50 clock = ~clock;
  assign sda = !sda_low && (sda_oe_n || sda_out);
  assign sel_one = strap[3] ? (strap[2] ? sda : scl) : strap[2];
  assign sel_zero = strap[1] ? (strap[0] ? sda : scl) : strap[0];
  assign rd_data = mem[reg_ptr[4:0]];
  always @(posedge clock) if (wr_strobe === 1'b1) mem[reg_ptr[4:0]] <= wr_data;

  ira_host_model host_u (.clock(clock), .sda(sda), .scl(scl), .sda_low(sda_low));
  ira_i2c_target dut_u (.clock(clock), .rstn(rstn), .scl(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .address_select_one(sel_one), .address_select_zero(sel_zero), .rd_data(rd_data),
    .reg_ptr(reg_ptr), .wr_data(wr_data), .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .ready(ready));

  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    comparisons++;
    if (seen !== want) begin
      fail_count++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, want);
    end
  endtask

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Strobes take the oldest note; a strobe with no note is itself a fault.
  always @(posedge clock) begin
    if (wr_strobe === 1'b1) check({reg_ptr, wr_data}, wq.size() ? wq.pop_front() : 16'hXXXX);
    if (rd_strobe === 1'b1) check({8'h00, reg_ptr}, {8'h00, rq.size() ? rq.pop_front() : 8'hXX});
  end

  // One access: head, optional repeated start, then n data bytes.
  task automatic access(input logic [7:0] ra, input int n, input bit rd);
    logic [7:0] q;
    logic [7:0] d;
    logic [7:0] p;
    logic a;
    p = ra;
    host_u.start();
    host_u.xfer(taddr, 1'b1, q, a);
    check({15'h0, a}, 16'h0);
    host_u.xfer(ra, 1'b1, q, a);
    check({15'h0, a}, {15'h0, ra > `IRA_REG_LAST});
    if (rd) begin
      host_u.start();
      host_u.xfer(taddr | 8'h01, 1'b1, q, a);
      check({15'h0, a}, 16'h0);
    end
    for (int k = 0; k < n; k++) begin
      d = rd ? 8'hFF : 8'($urandom);
      if (rd) rq.push_back(p);
      else if (ra <= `IRA_REG_LAST) wq.push_back({p, d});
      host_u.xfer(d, !rd || k == n - 1, q, a);
      if (rd) check({8'h00, q}, {8'h00, shadow[p[4:0]]});
      else check({15'h0, a}, {15'h0, ra > `IRA_REG_LAST});
      if (!rd && ra <= `IRA_REG_LAST) shadow[p[4:0]] = d;
      if (p != `IRA_REG_FIFO) p = p + 8'h01;
    end
    host_u.stop();
  endtask

  // Host start-up poll: read a register of known contents until the target
  // answers with them; the first try falls inside the start-up time.
  task automatic poll_ready();
    logic [7:0] q;
    logic a;
    int tries;
    bit got;
    tries = 0;
    got = 1'b0;
    while (!got && tries < 40) begin
      host_u.start();
      host_u.xfer(taddr, 1'b1, q, a);
      if (tries == 0) check({15'h0, a}, 16'h1);
      if (!a) begin
        host_u.xfer(8'h1D, 1'b1, q, a);
        host_u.start();
        host_u.xfer(taddr | 8'h01, 1'b1, q, a);
        rq.push_back(8'h1D);
        host_u.xfer(8'hFF, 1'b1, q, a);
        check({8'h00, q}, {8'h00, shadow[5'h1D]});
        got = (q === shadow[5'h1D]);
      end
      host_u.stop();
      tries++;
    end
    check({15'h0, got}, 16'h1);
  endtask

  // Watchdog well beyond the expected run of about 11400 cycles.
  initial begin
    #5000000;
    fail_count++;
    wrap_up();
  end

  // =====================================================
  // Main sequence.
  initial begin
    logic [7:0] q;
    logic a;
    void'($urandom(13269));
    for (int i = 0; i < 32; i++) mem[i] = 8'h00;
    for (int i = 0; i < 32; i++) shadow[i] = 8'h00;
    repeat (5) @(posedge clock);
    #5;
    check({reg_ptr, 7'h0, sda_oe_n}, 16'h0001);
    rstn = 1'b1;
    repeat (1990) @(posedge clock);
    #5;
    check({15'h0, ready}, 16'h0);
    repeat (15) @(posedge clock);
    #5;
    check({15'h0, ready}, 16'h1);
    // Every strap pair: a neighbour address is ignored, its own is taken.
    for (int c = 0; c < 16; c++) begin
      strap = c[3:0];
      host_u.start();
      host_u.xfer(tab[c] ^ 8'h02, 1'b1, q, a);
      check({15'h0, a}, 16'h1);
      host_u.xfer(8'h00, 1'b1, q, a);
      check({15'h0, a}, 16'h1);
      host_u.stop();
      host_u.start();
      host_u.xfer(tab[c], 1'b1, q, a);
      check({15'h0, a}, 16'h0);
      host_u.stop();
    end
    strap = 4'h0;
    access(8'h1D, 3, 1'b0);
    access(`IRA_REG_FIFO, 3, 1'b0);
    access(8'h05, 1, 1'b0);
    access(8'h20, 2, 1'b0);
    access(8'h1E, 1, 1'b1);
    access(8'h1D, 3, 1'b1);
    access(`IRA_REG_FIFO, 2, 1'b1);
    access(8'h05, 1, 1'b1);
    // Mid-run reset: outputs return to rest, then the host polls until answered.
    rstn = 1'b0;
    repeat (2) @(posedge clock);
    #5;
    check({reg_ptr, 7'h0, sda_oe_n}, 16'h0001);
    rstn = 1'b1;
    poll_ready();
    check({15'h0, wq.size() == 0 && rq.size() == 0}, 16'h1);
    wrap_up();
  end
endmodule
